// ==== design/reconfig_status_pkg.sv ====
// Shared constants and types for the reconfiguration status controller.
// Assumes a single 10 MHz system clock and an active-low asynchronous reset.
package reconfig_status_pkg;

    // Clock and watchdog kick timing.
    localparam int CLK_PERIOD_NS = 100;
    localparam int WD_PULSE_NS = 250;
    localparam int WD_PULSE_CYC = (WD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WD_KICK_CYC_DEF = 33554432;
    localparam int KICK_CNT_W = 26;

    // Parameter select codes of the update circuitry.
    localparam logic [1:0] PARAM_CAUSE = 2'h0;
    localparam logic [1:0] PARAM_WD_EN = 2'h1;
    localparam logic [1:0] PARAM_WD_VAL = 2'h2;
    localparam logic [1:0] PARAM_BOOT = 2'h3;

    // Read source codes.
    localparam logic [1:0] SRC_CURRENT = 2'h0;
    localparam logic [1:0] SRC_PREVIOUS = 2'h1;

    // Bit positions of the reconfiguration cause word.
    localparam int CAUSE_CORE_BIT = 0;
    localparam int CAUSE_CRC_BIT = 1;
    localparam int CAUSE_ERR_BIT = 2;
    localparam int CAUSE_WDOG_BIT = 3;
    localparam int CAUSE_PIN_BIT = 4;

    // Boot addresses and watchdog setup written by the factory image.
    localparam logic [21:0] APP1_BOOT_ADDR = 22'h010000;
    localparam logic [21:0] APP2_BOOT_ADDR = 22'h020000;
    localparam logic [21:0] WD_ENABLE_VAL = 22'h000001;
    localparam logic [21:0] WD_TIMEOUT_VAL = 22'h000100;

    // Indicator patterns, bit 3 is indicator 4.
    localparam logic [3:0] IND_FACTORY = 4'hf;
    localparam logic [3:0] IND_WD_APP1 = 4'ha;
    localparam logic [3:0] IND_WD_APP2 = 4'h3;
    localparam logic [3:0] IND_ERR_APP1 = 4'h9;
    localparam logic [3:0] IND_ERR_APP2 = 4'h4;
    localparam logic [3:0] IND_CRC_APP1 = 4'h5;
    localparam logic [3:0] IND_CRC_APP2 = 4'h6;
    localparam logic [3:0] IND_PIN_APP1 = 4'he;
    localparam logic [3:0] IND_PIN_APP2 = 4'h1;
    localparam logic [3:0] IND_APP_BASE = 4'hc;
    localparam int BLINK_APP1_BIT = 0;
    localparam int BLINK_APP2_BIT = 1;

    // Access sequence lengths, counted as the index of the last access.
    localparam logic [2:0] LAST_STEP_FACTORY = 3'h4;
    localparam logic [2:0] LAST_STEP_APP = 3'h2;

    typedef enum logic [1:0] {IMG_FACTORY, IMG_APP1, IMG_APP2} image_t;

    typedef struct packed {
        logic wr;
        logic [1:0] param;
        logic [1:0] src;
        logic [21:0] data;
    } access_t;

endpackage

// ==== design/cycle_ticker.sv ====
// Free-running period counter that emits a one-cycle tick.
// Assumes the enable is synchronous; the count restarts while disabled.
module cycle_ticker
    import reconfig_status_pkg::*;
#(
    parameter int W = 26,
    parameter int unsigned PERIOD = 16
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Control and tick.
    input wire logic en_i,
    output logic tick_o
);
    logic [W-1:0] cnt_ff;
    wire logic at_end = (cnt_ff == W'(PERIOD - 1));

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_ff <= '0;
        end else if (!en_i || at_end) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + W'(1);
        end
    end

    assign tick_o = en_i && at_end;
endmodule

// ==== design/reconfig_status_controller.sv ====
// Control logic between board status indicators and the remote update circuitry.
// Assumes all inputs are synchronous to mclk_i and the image role strap is stable.

// Function
// - Factory image after power-up or core reconfig request shows pattern 1111.
// - Watchdog time-out fallback shows 1010 for image 1, 0011 for image 2.
// - Configuration error line fallback shows 1001 for image 1, 0100 for image 2.
// - CRC error fallback shows 0101 for image 1, 0110 for image 2.
// - External reconfig pin fallback shows 1110 for image 1, 0001 for image 2.
// - Image 1 running holds 110 on upper indicators, indicator 1 blinks with watchdog.
// - Image 2 running drives 11x0, indicator 2 blinks while watchdog kicking runs.
// - A one bit lights an indicator, zero darkens it, blinking toggles periodically.
// - Start input launches the parameter access sequence before any reconfiguration.
// - Current state is exposed on an eight-bit monitor bus.
// - Monitor bus bit 7 is the reconfiguration request to the update circuitry.
// - While busy is high the current access is still in progress.
// - Two-bit select names the parameter of each access.
// - Write data is presented on a 22-bit bus for the selected parameter.
// - Two-bit read source picks current or previous state values.
// - A read strobe requests reading the selected parameter.
// - Controller, watchdog kicker and update interface share the board clock.
// - Both image types carry the flash loader for user-mode flash updates.
// - Update circuitry clock is the board clock divided by two.
// - Each watchdog reset pulse stays high at least 250 ns.
// - Fault injection stops watchdog reset pulses so the watchdog expires.
module reconfig_status_controller
    import reconfig_status_pkg::*;
#(
    parameter int unsigned WD_KICK_CYC = WD_KICK_CYC_DEF
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Board side.
    input wire image_t image_role_i,
    input wire logic next_app2_i,
    input wire logic start_i,
    input wire logic watchdog_fault_inject_i,
    output logic [3:0] status_indicator_o,
    output logic [7:0] state_mon_o,
    // Remote update circuitry side.
    input wire logic busy_i,
    input wire logic [28:0] rd_data_i,
    output logic upd_clk_o,
    output logic [1:0] param_sel_o,
    output logic [21:0] wr_data_o,
    output logic [1:0] read_source_o,
    output logic read_param_o,
    output logic write_param_o,
    output logic reconfig_o,
    output logic wd_reset_o
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ISSUE, ST_SETTLE, ST_WAIT, ST_NEXT, ST_RECONFIG
    } state_t;

    state_t state_ff, nxt_state;
    logic [2:0] step_ff;
    logic [4:0] cause_ff;
    logic prev_app2_ff;
    logic status_known_ff;
    logic [3:0] ind_ff;
    logic [7:0] mon_ff;
    logic reconfig_ff;
    logic upd_clk_ff;
    access_t acc_ff;
    logic rd_strobe_ff;
    logic wr_strobe_ff;
    logic [1:0] pulse_cnt_ff;
    logic wd_reset_ff;
    logic blink_ff;

    wire logic is_factory = (image_role_i == IMG_FACTORY);
    wire logic is_app1 = (image_role_i == IMG_APP1);
    wire logic is_app2 = (image_role_i == IMG_APP2);
    wire logic [2:0] last_step = is_factory ? LAST_STEP_FACTORY : LAST_STEP_APP;
    wire logic [21:0] next_boot = next_app2_i ? APP2_BOOT_ADDR : APP1_BOOT_ADDR;

    // The factory image learns the cause first, then programs the next boot.
    function automatic access_t step_access(input logic factory, input logic [2:0] step,
                                            input logic [21:0] boot);
        access_t a;
        a = '{wr: 1'b0, param: PARAM_CAUSE, src: SRC_CURRENT, data: 22'h000000};
        if (factory) begin
            unique case (step)
                3'h0: a = '{wr: 1'b0, param: PARAM_CAUSE, src: SRC_PREVIOUS, data: 22'h000000};
                3'h1: a = '{wr: 1'b0, param: PARAM_BOOT, src: SRC_PREVIOUS, data: 22'h000000};
                3'h2: a = '{wr: 1'b1, param: PARAM_BOOT, src: SRC_CURRENT, data: boot};
                3'h3: a = '{wr: 1'b1, param: PARAM_WD_EN, src: SRC_CURRENT, data: WD_ENABLE_VAL};
                default: a = '{wr: 1'b1, param: PARAM_WD_VAL, src: SRC_CURRENT,
                               data: WD_TIMEOUT_VAL};
            endcase
        end else begin
            unique case (step)
                3'h0: a = '{wr: 1'b0, param: PARAM_BOOT, src: SRC_CURRENT, data: 22'h000000};
                3'h1: a = '{wr: 1'b0, param: PARAM_WD_EN, src: SRC_CURRENT, data: 22'h000000};
                default: a = '{wr: 1'b0, param: PARAM_WD_VAL, src: SRC_CURRENT,
                               data: 22'h000000};
            endcase
        end
        return a;
    endfunction

    wire access_t cur_acc = step_access(is_factory, step_ff, next_boot);

    // Sequencer.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: if (start_i) nxt_state = ST_ISSUE;
            ST_ISSUE: if (!busy_i) nxt_state = ST_SETTLE;
            ST_SETTLE: nxt_state = ST_WAIT;
            ST_WAIT: if (!busy_i) nxt_state = ST_NEXT;
            ST_NEXT: nxt_state = (step_ff == last_step) ? ST_RECONFIG : ST_ISSUE;
            ST_RECONFIG: nxt_state = ST_RECONFIG;
            default: nxt_state = ST_IDLE;
        endcase
    end

    wire logic issue_now = (state_ff == ST_ISSUE) && !busy_i;
    wire logic access_done = (state_ff == ST_WAIT) && !busy_i;
    // Reconfiguration is only raised once the last access has fully drained.
    wire logic nxt_reconfig = (nxt_state == ST_RECONFIG) && !busy_i;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= ST_IDLE;
        end else if (state_ff != ST_RECONFIG || reconfig_ff) begin
            state_ff <= nxt_state;
        end else begin
            state_ff <= ST_RECONFIG;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            step_ff <= 3'h0;
        end else if (state_ff == ST_NEXT) begin
            step_ff <= step_ff + 3'h1;
        end
    end

    // Access strobes, select, source and write data are all registered.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acc_ff <= '0;
            rd_strobe_ff <= 1'b0;
            wr_strobe_ff <= 1'b0;
        end else begin
            if (issue_now) acc_ff <= cur_acc;
            rd_strobe_ff <= issue_now && !cur_acc.wr;
            wr_strobe_ff <= issue_now && cur_acc.wr;
        end
    end

    // Capture of the cause word and the previously running image.
    wire logic cap_cause = access_done && is_factory && (step_ff == 3'h0);
    wire logic cap_boot = access_done && is_factory && (step_ff == 3'h1);

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cause_ff <= 5'h00;
            prev_app2_ff <= 1'b0;
            status_known_ff <= 1'b0;
        end else begin
            if (cap_cause) cause_ff <= rd_data_i[4:0];
            if (cap_boot) prev_app2_ff <= (rd_data_i[21:0] == APP2_BOOT_ADDR);
            if (cap_boot) status_known_ff <= 1'b1;
        end
    end

    // Fallback cause decode; a watchdog expiry is ranked first as it is the
    // most specific report, and a core request falls through to all-on.
    wire logic [3:0] fallback_ind =
        cause_ff[CAUSE_WDOG_BIT] ? (prev_app2_ff ? IND_WD_APP2 : IND_WD_APP1) :
        cause_ff[CAUSE_ERR_BIT] ? (prev_app2_ff ? IND_ERR_APP2 : IND_ERR_APP1) :
        cause_ff[CAUSE_CRC_BIT] ? (prev_app2_ff ? IND_CRC_APP2 : IND_CRC_APP1) :
        cause_ff[CAUSE_PIN_BIT] ? (prev_app2_ff ? IND_PIN_APP2 : IND_PIN_APP1) :
        IND_FACTORY;
    wire logic [3:0] app1_ind = IND_APP_BASE | (4'(blink_ff) << BLINK_APP1_BIT);
    wire logic [3:0] app2_ind = IND_APP_BASE | (4'(blink_ff) << BLINK_APP2_BIT);
    wire logic [3:0] nxt_ind = is_app1 ? app1_ind :
                               is_app2 ? app2_ind :
                               status_known_ff ? fallback_ind : IND_FACTORY;

    // Watchdog kicking runs only in an application image and stops on fault.
    wire logic kick_en = !is_factory && !watchdog_fault_inject_i;
    logic kick_tick;

    cycle_ticker #(
        .W(KICK_CNT_W),
        .PERIOD(WD_KICK_CYC)
    ) u_kick_ticker (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .en_i(kick_en),
        .tick_o(kick_tick)
    );

    wire logic [1:0] nxt_pulse_cnt = kick_tick ? 2'(WD_PULSE_CYC) :
                                     (pulse_cnt_ff != 2'h0) ? pulse_cnt_ff - 2'h1 : 2'h0;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pulse_cnt_ff <= 2'h0;
            wd_reset_ff <= 1'b0;
            blink_ff <= 1'b0;
        end else begin
            pulse_cnt_ff <= nxt_pulse_cnt;
            wd_reset_ff <= (nxt_pulse_cnt != 2'h0);
            if (kick_tick) blink_ff <= !blink_ff;
        end
    end

    // Monitor, request, indicators and the halved update clock.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mon_ff <= 8'h00;
            reconfig_ff <= 1'b0;
            ind_ff <= IND_FACTORY;
            upd_clk_ff <= 1'b0;
        end else begin
            mon_ff <= {nxt_reconfig, 4'h0, nxt_state};
            reconfig_ff <= nxt_reconfig;
            ind_ff <= nxt_ind;
            upd_clk_ff <= !upd_clk_ff;
        end
    end

    assign status_indicator_o = ind_ff;
    assign state_mon_o = mon_ff;
    assign reconfig_o = reconfig_ff;
    assign upd_clk_o = upd_clk_ff;
    assign param_sel_o = acc_ff.param;
    assign wr_data_o = acc_ff.data;
    assign read_source_o = acc_ff.src;
    assign read_param_o = rd_strobe_ff;
    assign write_param_o = wr_strobe_ff;
    assign wd_reset_o = wd_reset_ff;

    property p_reconfig_after_idle;
        @(posedge mclk_i) disable iff (!reset_n_i)
        $rose(reconfig_o) |-> !$past(busy_i) && state_mon_o[7];
    endproperty
    a_reconfig_after_idle: assert property (p_reconfig_after_idle)
        else $error("reconfig raised while busy or off monitor bit");

    property p_powerup_all_on;
        @(posedge mclk_i) disable iff (!reset_n_i)
        is_factory && !status_known_ff ##1 is_factory |-> status_indicator_o == 4'hf;
    endproperty
    a_powerup_all_on: assert property (p_powerup_all_on)
        else $error("factory indicators not all on before status read");

    property p_wdog_pattern;
        @(posedge mclk_i) disable iff (!reset_n_i)
        is_factory && status_known_ff && cause_ff[CAUSE_WDOG_BIT] ##1 is_factory
        |-> status_indicator_o == ($past(prev_app2_ff) ? 4'h3 : 4'ha);
    endproperty
    a_wdog_pattern: assert property (p_wdog_pattern)
        else $error("watchdog fallback pattern wrong");

    property p_crc_pattern;
        @(posedge mclk_i) disable iff (!reset_n_i)
        is_factory && status_known_ff && cause_ff == 5'h02 ##1 is_factory
        |-> status_indicator_o == ($past(prev_app2_ff) ? 4'h6 : 4'h5);
    endproperty
    a_crc_pattern: assert property (p_crc_pattern)
        else $error("crc fallback pattern wrong");

    property p_app1_upper;
        @(posedge mclk_i) disable iff (!reset_n_i)
        reset_n_i && is_app1 ##1 is_app1 |-> status_indicator_o[3:1] == 3'b110;
    endproperty
    a_app1_upper: assert property (p_app1_upper)
        else $error("image 1 upper indicators wrong");

    property p_app2_fixed;
        @(posedge mclk_i) disable iff (!reset_n_i)
        reset_n_i && is_app2 ##1 is_app2
        |-> status_indicator_o[3:2] == 2'b11 && !status_indicator_o[0];
    endproperty
    a_app2_fixed: assert property (p_app2_fixed)
        else $error("image 2 fixed indicators wrong");

    property p_kick_width;
        @(posedge mclk_i) disable iff (!reset_n_i)
        $rose(wd_reset_o) |-> wd_reset_o [*3];
    endproperty
    a_kick_width: assert property (p_kick_width)
        else $error("watchdog reset pulse shorter than three cycles");

    property p_fault_stops_kick;
        @(posedge mclk_i) disable iff (!reset_n_i)
        watchdog_fault_inject_i |=> !$rose(wd_reset_o);
    endproperty
    a_fault_stops_kick: assert property (p_fault_stops_kick)
        else $error("watchdog reset pulse despite fault injection");

    property p_clk_halved;
        @(posedge mclk_i) disable iff (!reset_n_i)
        reset_n_i ##1 1'b1 |-> upd_clk_o != $past(upd_clk_o);
    endproperty
    a_clk_halved: assert property (p_clk_halved)
        else $error("update clock not toggling every cycle");

    property p_read_strobe;
        @(posedge mclk_i) disable iff (!reset_n_i)
        read_param_o |-> !$past(busy_i) ##1 !read_param_o;
    endproperty
    a_read_strobe: assert property (p_read_strobe)
        else $error("read strobe issued while busy or longer than a cycle");

    property p_start_launch;
        @(posedge mclk_i) disable iff (!reset_n_i)
        state_ff == ST_IDLE && start_i |=> state_ff == ST_ISSUE ##1 !reconfig_o;
    endproperty
    a_start_launch: assert property (p_start_launch)
        else $error("start did not launch the access sequence");

    property p_err_pattern;
        @(posedge mclk_i) disable iff (!reset_n_i)
        is_factory && status_known_ff && cause_ff[CAUSE_ERR_BIT] && !cause_ff[CAUSE_WDOG_BIT]
        ##1 is_factory |-> status_indicator_o == ($past(prev_app2_ff) ? 4'h4 : 4'h9);
    endproperty
    a_err_pattern: assert property (p_err_pattern)
        else $error("error line fallback pattern wrong");

    property p_pin_pattern;
        @(posedge mclk_i) disable iff (!reset_n_i)
        is_factory && status_known_ff && cause_ff == 5'h10 ##1 is_factory
        |-> status_indicator_o == ($past(prev_app2_ff) ? 4'h1 : 4'he);
    endproperty
    a_pin_pattern: assert property (p_pin_pattern)
        else $error("reconfig pin fallback pattern wrong");

    property p_write_strobe;
        @(posedge mclk_i) disable iff (!reset_n_i)
        write_param_o |-> !$past(busy_i) ##1 !write_param_o;
    endproperty
    a_write_strobe: assert property (p_write_strobe)
        else $error("write strobe issued while busy or longer than a cycle");

    property p_busy_holds_wait;
        @(posedge mclk_i) disable iff (!reset_n_i)
        state_ff == ST_WAIT && busy_i |=> state_ff == ST_WAIT;
    endproperty
    a_busy_holds_wait: assert property (p_busy_holds_wait)
        else $error("access left the wait state while busy");
endmodule

// ==== sim/upd_circuit_model.sv ====
// Behavioural model of the remote update circuitry behind the parameter access port.
// Assumes one-cycle strobes on mclk_i; the bench sets the answer delay and stored words.
module upd_circuit_model
    import reconfig_status_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Access port.
    input wire logic read_param_i,
    input wire logic write_param_i,
    input wire logic [1:0] param_sel_i,
    input wire logic [21:0] wr_data_i,
    // Bench controls.
    input wire logic [2:0] delay_i,
    input wire logic [4:0] cause_i,
    input wire logic [21:0] boot_i,
    // Answer.
    output logic busy_o,
    output logic [28:0] rd_data_o
);
    logic [21:0] wd_en_ff;
    logic [21:0] wd_val_ff;
    logic [2:0] cnt_ff;
    logic [28:0] val_ff;
    wire logic [28:0] word = (param_sel_i == PARAM_CAUSE) ? {24'h0, cause_i} :
        (param_sel_i == PARAM_BOOT) ? {7'h0, boot_i} :
        (param_sel_i == PARAM_WD_EN) ? {7'h0, wd_en_ff} : {7'h0, wd_val_ff};

    // Read data churns while busy so a capture taken too early shows up as a mismatch.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_o <= 1'b0;
            cnt_ff <= 3'h0;
            val_ff <= 29'h0;
            rd_data_o <= 29'h0;
            wd_en_ff <= 22'h0;
            wd_val_ff <= 22'h0;
        end else if (read_param_i | write_param_i) begin
            if (write_param_i && param_sel_i == PARAM_WD_EN) wd_en_ff <= wr_data_i;
            if (write_param_i && param_sel_i == PARAM_WD_VAL) wd_val_ff <= wr_data_i;
            val_ff <= word;
            cnt_ff <= delay_i;
            busy_o <= (delay_i != 3'h0);
            rd_data_o <= (delay_i == 3'h0) ? word : ~rd_data_o;
        end else if (cnt_ff > 3'h1) begin
            cnt_ff <= cnt_ff - 3'h1;
            rd_data_o <= ~rd_data_o;
        end else if (cnt_ff == 3'h1) begin
            cnt_ff <= 3'h0;
            busy_o <= 1'b0;
            rd_data_o <= val_ff;
        end
    end
endmodule

// ==== sim/test_reconfig_status_controller.sv ====
// Self-checking bench for the reconfiguration status controller.
// Assumes the update circuitry model answers every strobe; one 10 MHz clock.
module test_reconfig_status_controller
    import reconfig_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic start = 1'b0;
    logic nxt2 = 1'b0;
    logic fault = 1'b0;
    image_t role = IMG_FACTORY;
    logic [4:0] cause_r = 5'h0;
    logic [21:0] boot_r = 22'h0;
    logic [2:0] delay_r = 3'h0;
    logic [3:0] ind;
    logic [7:0] mon;
    logic busy, upd_clk, rdp, wrp, rcfg, wdr;
    logic [28:0] rdd;
    logic [1:0] psel, rsrc;
    logic [21:0] wdat;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;

    reconfig_status_controller #(.WD_KICK_CYC(20)) dut (.mclk_i(clk), .reset_n_i(reset_n),
        .image_role_i(role), .next_app2_i(nxt2), .start_i(start),
        .watchdog_fault_inject_i(fault), .status_indicator_o(ind), .state_mon_o(mon),
        .busy_i(busy), .rd_data_i(rdd), .upd_clk_o(upd_clk), .param_sel_o(psel),
        .wr_data_o(wdat), .read_source_o(rsrc), .read_param_o(rdp), .write_param_o(wrp),
        .reconfig_o(rcfg), .wd_reset_o(wdr));
    upd_circuit_model model (.mclk_i(clk), .reset_n_i(reset_n), .read_param_i(rdp),
        .write_param_i(wrp), .param_sel_i(psel), .wr_data_i(wdat), .delay_i(delay_r),
        .cause_i(cause_r), .boot_i(boot_r), .busy_o(busy), .rd_data_o(rdd));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic test_done();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // The ceiling leaves ample slack over the roughly 1000 cycles the run needs.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [28:0] e, input logic [28:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [3:0] exp_ind(input logic [4:0] c, input logic a2);
        if (c[3]) return a2 ? 4'b0011 : 4'b1010;
        if (c[2]) return a2 ? 4'b0100 : 4'b1001;
        if (c[1]) return a2 ? 4'b0110 : 4'b0101;
        if (c[4]) return a2 ? 4'b0001 : 4'b1110;
        return 4'b1111;
    endfunction

    function automatic access_t exp_acc(input logic fac, input int k);
        access_t a;
        a = '0;
        if (fac) begin
            a.param = (k == 0) ? PARAM_CAUSE : (k < 3) ? PARAM_BOOT :
                (k == 3) ? PARAM_WD_EN : PARAM_WD_VAL;
            a.wr = (k > 1);
            a.src = SRC_PREVIOUS;
            a.data = (k == 2) ? (nxt2 ? 22'h020000 : 22'h010000) :
                (k == 3) ? 22'h000001 : 22'h000100;
        end else begin
            a.param = (k == 0) ? PARAM_BOOT : (k == 1) ? PARAM_WD_EN : PARAM_WD_VAL;
            a.src = SRC_CURRENT;
        end
        return a;
    endfunction

    task automatic do_reset();
        @(posedge clk);
        reset_n <= 1'b0;
        start <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("ind_reset", 4'hf, ind);
        chk("mon_reset", 8'h0, mon);
        @(posedge clk);
        reset_n <= 1'b1;
    endtask

    task automatic run_seq(input logic fac);
        int k;
        access_t e;
        k = 0;
        @(posedge clk);
        start <= 1'b1;
        for (int n = 0; n < 500 && rcfg !== 1'b1; n++) begin
            @(posedge clk);
            #1;
            if ((rdp | wrp) === 1'b1) begin
                e = exp_acc(fac, k);
                chk("acc_kind", {e.wr, ~e.wr, e.param}, {wrp, rdp, psel});
                if (e.wr) chk("wr_data", e.data, wdat);
                else chk("rd_src", e.src, rsrc);
                k++;
            end
        end
        chk("acc_count", fac ? 5 : 3, k);
        chk("reconfig", 1'b1, rcfg);
        chk("mon_msb", 1'b1, mon[7]);
        chk("mon_reconfig", 8'h85, mon);
    endtask

    task automatic watch(input logic flt, input logic a2);
        int kicks, flips, run;
        logic pc, pb;
        @(posedge clk);
        #1;
        kicks = 0;
        flips = 0;
        run = (wdr === 1'b1) ? -8 : 0;
        pc = upd_clk;
        pb = ind[a2];
        repeat (50) begin
            @(posedge clk);
            #1;
            chk("upd_clk", !pc, upd_clk);
            chk("ind_fixed", 3'b110, a2 ? {ind[3], ind[2], ind[0]} : ind[3:1]);
            if (ind[a2] !== pb) flips++;
            if (wdr === 1'b1) begin
                if (run == 0) kicks++;
                run++;
            end else begin
                if (run > 0) chk("wd_pulse_len", 3, run);
                run = 0;
            end
            pc = upd_clk;
            pb = ind[a2];
        end
        chk("wd_kicks", flt ? 0 : 2, kicks);
        chk("blink_flips", flt ? 0 : 2, flips);
    endtask

    task automatic do_factory(input logic [4:0] c, input logic a2);
        @(posedge clk);
        role <= IMG_FACTORY;
        cause_r <= c;
        boot_r <= a2 ? 22'h020000 : 22'h010000;
        nxt2 <= 1'($urandom);
        delay_r <= 3'($urandom_range(0, 6));
        do_reset();
        @(posedge clk);
        #1;
        chk("mon_idle", 8'h0, mon);
        run_seq(1'b1);
        chk("ind_fallback", exp_ind(c, a2), ind);
    endtask

    task automatic do_app(input logic a2);
        @(posedge clk);
        role <= a2 ? IMG_APP2 : IMG_APP1;
        boot_r <= a2 ? 22'h020000 : 22'h010000;
        fault <= 1'b0;
        delay_r <= 3'($urandom_range(0, 6));
        do_reset();
        watch(1'b0, a2);
        @(posedge clk);
        fault <= 1'b1;
        repeat (5) @(posedge clk);
        watch(1'b1, a2);
        run_seq(1'b0);
    endtask

    initial begin
        void'($urandom(32'h53e3));
        for (int c = 0; c < 12; c++) begin
            do_factory((c % 6 == 0) ? 5'h0 : 5'(5'h1 << (c % 6 - 1)), 1'(c / 6));
        end
        repeat (4) do_factory(5'($urandom), 1'($urandom));
        do_app(1'b0);
        do_app(1'b1);
        test_done();
    end
endmodule
